/* File: include/scsel_pkg.sv */
// Package with register map, field positions, reset values and timing constants.
package scsel_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] serial_control_addr = 12'h000;
  localparam logic [11:0] serial_status_addr  = 12'h004;
  localparam logic [11:0] mode_addr           = 12'h008;
  localparam logic [11:0] baud_div_addr       = 12'h00c;
  localparam logic [11:0] tx_data_addr        = 12'h010;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int tx_done_irq_enable_bit     = 2;
  localparam int clock_source_select_hi_bit = 1;
  localparam int clock_source_select_lo_bit = 0;
  localparam int tx_holding_empty_bit       = 7;
  localparam int tx_done_bit                = 2;
  localparam int sync_mode_bit              = 0;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] serial_control_rst = 8'h00;
  localparam logic [7:0] baud_div_rst       = 8'h0f;
  localparam logic [7:0] status_rst         = 8'h84;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int ext_oversample = 16;
  localparam logic [3:0] ext_last_tick = 4'hf;
  localparam logic [3:0] frame_bits    = 4'ha;
  localparam logic [3:0] sync_bits     = 4'h8;
  typedef enum logic [1:0] {
    scsel_idle_s  = 2'b00,
    scsel_shift_s = 2'b01
  } scsel_state_t;
endpackage

/* File: src/scsel_edge_sync.sv */
// Two-flop synchroniser with rising-edge pulse on the synchronised level.
`timescale 1ns/1ps
`default_nettype none
module scsel_edge_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output logic      level,
  output logic      rise
);
  logic meta;
  logic last;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta  <= 1'b0;
      level <= 1'b0;
      last  <= 1'b0;
    end else begin
      meta  <= async_in;
      level <= meta;
      last  <= level;
    end
  end
  assign rise = level & ~last;
endmodule // scsel_edge_sync
`default_nettype wire

/* File: src/scsel_top.sv */
// Serial control: transmit-end interrupt enable and clock source selection.
`timescale 1ns/1ps
`default_nettype none
module scsel_top (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  output logic             txd,
  output logic             tx_done_irq
);
  logic [7:0] serial_control;
  logic       sync_mode;
  logic [7:0] baud_div;
  logic [7:0] tx_data;
  logic       tx_holding_empty_flag;
  logic       tx_done_flag;
  logic       empty_seen;
  logic [7:0] baud_cnt;
  logic       bit_clk;
  logic [3:0] ext_cnt;
  logic [3:0] bit_cnt;
  logic [9:0] shifter;
  logic       sck_rise;
  logic       bit_tick;
  logic       start_tx;
  logic       wr;
  logic       rd;
  scsel_pkg::scsel_state_t state;
  wire logic tx_done_irq_enable     = serial_control[scsel_pkg::tx_done_irq_enable_bit];
  wire logic clock_source_select_hi = serial_control[scsel_pkg::clock_source_select_hi_bit];
  wire logic clock_source_select_lo = serial_control[scsel_pkg::clock_source_select_lo_bit];
  // ****************************************************************
  // Bus slave
  // ****************************************************************
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      serial_control <= scsel_pkg::serial_control_rst;
      sync_mode      <= 1'b0;
      baud_div       <= scsel_pkg::baud_div_rst;
      tx_data        <= 8'h00;
    end else if (wr) begin
      unique case (paddr)
        scsel_pkg::serial_control_addr: serial_control <= {5'h00, pwdata[2:0]};
        scsel_pkg::mode_addr:           sync_mode      <= pwdata[scsel_pkg::sync_mode_bit];
        scsel_pkg::baud_div_addr:       baud_div       <= pwdata[7:0];
        scsel_pkg::tx_data_addr:        tx_data        <= pwdata[7:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel & ~penable) begin
        unique case (paddr)
          scsel_pkg::serial_control_addr: prdata <= {24'h0, serial_control};
          scsel_pkg::serial_status_addr:
            prdata <= {24'h0, tx_holding_empty_flag, 4'h0, tx_done_flag, 2'b00};
          scsel_pkg::mode_addr:     prdata <= {31'h0, sync_mode};
          scsel_pkg::baud_div_addr: prdata <= {24'h0, baud_div};
          scsel_pkg::tx_data_addr:  prdata <= {24'h0, tx_data};
          default:                  pslverr <= 1'b1;
        endcase
      end
    end
  end
  // ****************************************************************
  // Status flags
  // ****************************************************************
  // A clear needs a prior read of the empty flag as 1, so software cannot drop it blindly.
  assign start_tx = wr && paddr == scsel_pkg::serial_status_addr && empty_seen
                    && !pwdata[scsel_pkg::tx_holding_empty_bit] && tx_holding_empty_flag;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      empty_seen            <= 1'b0;
      tx_holding_empty_flag <= 1'b1;
      tx_done_flag          <= 1'b1;
    end else begin
      if (rd && paddr == scsel_pkg::serial_status_addr && tx_holding_empty_flag)
        empty_seen <= 1'b1;
      else if (start_tx)
        empty_seen <= 1'b0;
      if (start_tx) begin
        tx_holding_empty_flag <= 1'b0;
        tx_done_flag          <= 1'b0;
      end else if (state == scsel_pkg::scsel_shift_s && bit_tick && bit_cnt == 4'h1) begin
        tx_holding_empty_flag <= 1'b1;
        tx_done_flag          <= 1'b1;
      end
    end
  end
  // ****************************************************************
  // Clock source
  // ****************************************************************
  scsel_edge_sync u_sck_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (sck_in),
    .level    (),
    .rise     (sck_rise)
  );
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      baud_cnt <= 8'h00;
      bit_clk  <= 1'b0;
      ext_cnt  <= 4'h0;
    end else begin
      if (baud_cnt == 8'h00) begin
        baud_cnt <= baud_div;
        bit_clk  <= ~bit_clk;
      end else begin
        baud_cnt <= baud_cnt - 8'h01;
      end
      if (sck_rise)
        ext_cnt <= ext_cnt + 4'h1;
    end
  end
  always_comb begin
    if (clock_source_select_hi) begin
      if (sync_mode)
        bit_tick = sck_rise;
      else
        bit_tick = sck_rise && ext_cnt == scsel_pkg::ext_last_tick;
    end else begin
      bit_tick = baud_cnt == 8'h00 && bit_clk;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sck_oe  <= 1'b0;
      sck_out <= 1'b0;
    end else begin
      sck_oe  <= !clock_source_select_hi && (sync_mode || clock_source_select_lo);
      sck_out <= sync_mode ? (bit_clk | state == scsel_pkg::scsel_idle_s) : bit_clk;
    end
  end
  // ****************************************************************
  // Transmitter
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state   <= scsel_pkg::scsel_idle_s;
      bit_cnt <= 4'h0;
      shifter <= 10'h3ff;
      txd     <= 1'b1;
    end else begin
      unique case (state)
        scsel_pkg::scsel_idle_s: begin
          if (start_tx) begin
            state   <= scsel_pkg::scsel_shift_s;
            shifter <= sync_mode ? {2'b11, tx_data} : {1'b1, tx_data, 1'b0};
            bit_cnt <= sync_mode ? scsel_pkg::sync_bits : scsel_pkg::frame_bits;
          end
        end
        scsel_pkg::scsel_shift_s: begin
          if (bit_tick) begin
            txd     <= shifter[0];
            shifter <= {1'b1, shifter[9:1]};
            bit_cnt <= bit_cnt - 4'h1;
            if (bit_cnt == 4'h1)
              state <= scsel_pkg::scsel_idle_s;
          end
        end
        default: state <= scsel_pkg::scsel_idle_s;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n)
      tx_done_irq <= 1'b0;
    else
      tx_done_irq <= tx_done_flag & tx_done_irq_enable;
  end
  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_irq_gate;
    @(posedge clk) disable iff (!reset_n) tx_done_irq |-> $past(tx_done_irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
  property p_disable_clears;
    @(posedge clk) disable iff (!reset_n) !tx_done_irq_enable |=> !tx_done_irq;
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("irq stayed");
  property p_start_clears;
    @(posedge clk) disable iff (!reset_n) start_tx |=> !tx_done_flag ##1 !tx_done_irq;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("done not cleared");
  property p_reset_vals;
    @(posedge clk) $rose(reset_n) |-> serial_control[2:0] == 3'b000;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
  property p_pin_released;
    @(posedge clk) disable iff (!reset_n)
      (!sync_mode && serial_control[1:0] == 2'b00) [*2] |-> !sck_oe;
  endproperty
  a_pin_released: assert property (p_pin_released) else $error("pin driven");
  property p_pin_out_async;
    @(posedge clk) disable iff (!reset_n)
      (!sync_mode && serial_control[1:0] == 2'b01) [*2] |-> sck_oe;
  endproperty
  a_pin_out_async: assert property (p_pin_out_async) else $error("no clk out");
  // A second count of pin rises, kept apart from ext_cnt, so a broken divider cannot hide.
  logic [4:0] ext_rises;
  logic       ext_primed;
  always_ff @(posedge clk) begin
    if (!reset_n || sync_mode || !clock_source_select_hi) begin
      ext_rises  <= 5'h00;
      ext_primed <= 1'b0;
    end else if (bit_tick) begin
      ext_rises  <= 5'h00;
      ext_primed <= 1'b1;
    end else if (sck_rise) begin
      ext_rises <= ext_rises + 5'h01;
    end
  end
  property p_ext_16;
    @(posedge clk) disable iff (!reset_n)
      (!sync_mode && clock_source_select_hi && bit_tick && ext_primed)
        |-> ext_rises == 5'(scsel_pkg::ext_oversample - 1);
  endproperty
  a_ext_16: assert property (p_ext_16) else $error("ext tick count");
  property p_sync_int;
    @(posedge clk) disable iff (!reset_n)
      (sync_mode && !clock_source_select_hi) [*2] |-> sck_oe;
  endproperty
  a_sync_int: assert property (p_sync_int) else $error("sync not output");
  property p_sync_ext;
    @(posedge clk) disable iff (!reset_n) $past(clock_source_select_hi) |-> !sck_oe;
  endproperty
  a_sync_ext: assert property (p_sync_ext) else $error("ext pin driven");
  c_irq:   cover property (@(posedge clk) disable iff (!reset_n) $rose(tx_done_irq));
  c_start: cover property (@(posedge clk) disable iff (!reset_n) start_tx);
  c_ext:   cover property (@(posedge clk) disable iff (!reset_n) clock_source_select_hi && bit_tick);
endmodule // scsel_top
`default_nettype wire

/* File: sim/scsel_peer.sv */
// Serial peer model that supplies the external clock on the shared clock pin.
`timescale 1ns/1ps
`default_nettype none
module scsel_peer (
  input  wire logic clk,
  input  wire logic run,
  output logic      sck
);
  logic [1:0] phase;
  // The clock stands still while run is low; a four-cycle period keeps both half
  // periods long enough for the block's two-flop synchroniser.
  always_ff @(posedge clk) begin
    if (!run) begin
      phase <= 2'h0;
      sck   <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      if (phase[0]) sck <= ~sck;
    end
  end
endmodule // scsel_peer
`default_nettype wire

/* File: sim/serial_clock_select_and_tx_end_irq_tb.sv */
// Self-checking testbench for the serial control block.
`timescale 1ns/1ps
`default_nettype none
module serial_clock_select_and_tx_end_irq_tb;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic        sck_in, sck_out, sck_oe, txd, tx_done_irq, peer_run, peer_sck;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  div;
  int          bad_count, samples_checked, n;
  // The block wins the pin while it drives; otherwise the peer clock is seen.
  assign sck_in = sck_oe ? sck_out : peer_sck;
  scsel_top scsel_top_inst (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .txd(txd),
    .tx_done_irq(tx_done_irq));
  scsel_peer scsel_peer_inst (.clk(clk), .run(peer_run), .sck(peer_sck));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 40);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk(0, 1, "no bus answer");
      report_and_stop();
    end
  endtask
  task automatic wait_done();
    for (int k = 0; k < 300; k++) begin
      apb(1'b0, scsel_pkg::serial_status_addr, 32'h0);
      if (rd[scsel_pkg::tx_done_bit] === 1'b1) return;
    end
    chk(0, 1, "frame never ended");
    report_and_stop();
  endtask
  task automatic start_tx(input logic [7:0] d);
    apb(1'b1, scsel_pkg::tx_data_addr, {24'h0, d});
    apb(1'b0, scsel_pkg::serial_status_addr, 32'h0);
    chk(rd, {24'h0, scsel_pkg::status_rst}, "status before start");
    apb(1'b1, scsel_pkg::serial_status_addr, 32'h0);
  endtask
  // Measures the start bit in clocks; data 0xff keeps only that bit low.
  task automatic low_time();
    n = 0;
    for (int k = 0; k < 400 && txd !== 1'b0; k++) @(negedge clk);
    while (txd === 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask
  // Measures one high half period of the driven pin clock, in clocks.
  task automatic sck_high();
    n = 0;
    for (int k = 0; k < 400 && sck_out !== 1'b0; k++) @(negedge clk);
    for (int k = 0; k < 400 && sck_out !== 1'b1; k++) @(negedge clk);
    while (sck_out === 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask
  function automatic logic exp_oe(input int m, input int s);
    return (m == 1) ? (s < 2) : (s == 1);
  endfunction
  task automatic irq_is(input logic v, input string what);
    repeat (3) @(negedge clk);
    chk(tx_done_irq, v, what);
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {reset_n, psel, penable, pwrite, peer_run} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(93785));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, scsel_pkg::serial_control_addr, 32'h0);
    chk(rd, 32'h0, "control reset");
    chk(tx_done_irq, 1'b0, "irq after reset");
    apb(1'b0, 12'h0f0, 32'h0);
    chk(err, 1'b1, "unmapped read");
    for (int k = 0; k < 6; k++) begin
      pwdata <= {29'h0, 3'($urandom)};
      @(posedge clk);
      apb(1'b1, scsel_pkg::serial_control_addr, pwdata);
      n = pwdata;
      apb(1'b0, scsel_pkg::serial_control_addr, 32'h0);
      chk(rd, n, "control readback");
      chk(tx_done_irq, n[2], "irq follows enable");
    end
    $display("test registers done");
    for (int m = 0; m < 2; m++) for (int s = 0; s < 4; s++) begin
      apb(1'b1, scsel_pkg::mode_addr, m);
      apb(1'b1, scsel_pkg::serial_control_addr, s);
      irq_is(1'b0, "irq idle");
      chk(sck_oe, exp_oe(m, s), "pin direction");
    end
    $display("test pin function done");
    div = 8'h01 + 8'($urandom % 4);
    apb(1'b1, scsel_pkg::mode_addr, 32'h0);
    apb(1'b1, scsel_pkg::baud_div_addr, {24'h0, div});
    apb(1'b1, scsel_pkg::serial_control_addr, 32'h4);
    start_tx(8'hff);
    low_time();
    chk(n, 2 * (div + 1), "internal bit time");
    chk(tx_done_irq, 1'b0, "irq mid frame");
    wait_done();
    irq_is(1'b1, "irq at end");
    apb(1'b1, scsel_pkg::serial_control_addr, 32'h0);
    irq_is(1'b0, "irq enable off");
    apb(1'b1, scsel_pkg::serial_control_addr, 32'h4);
    irq_is(1'b1, "irq enable on");
    start_tx(8'($urandom));
    irq_is(1'b0, "irq flag cleared");
    wait_done();
    apb(1'b1, scsel_pkg::serial_control_addr, 32'h1);
    sck_high();
    chk(n, div + 1, "bit rate clock out");
    $display("test internal clock done");
    apb(1'b1, scsel_pkg::serial_control_addr, 32'h2);
    peer_run <= 1'b1;
    start_tx(8'hff);
    low_time();
    // The peer clock has a period of four clocks.
    chk(n, scsel_pkg::ext_oversample * 4, "external 16x bit time");
    wait_done();
    peer_run <= 1'b0;
    apb(1'b1, scsel_pkg::mode_addr, 32'h1);
    apb(1'b1, scsel_pkg::serial_control_addr, 32'h3);
    start_tx(8'($urandom));
    peer_run <= 1'b1;
    wait_done();
    peer_run <= 1'b0;
    apb(1'b1, scsel_pkg::serial_control_addr, 32'h1);
    start_tx(8'($urandom));
    wait_done();
    $display("test external clock done");
    report_and_stop();
  end
endmodule // serial_clock_select_and_tx_end_irq_tb
`default_nettype wire
